// ---- sim_pkg.sv ----
// Package for the limited increment monitor: timing, field and reset constants.
// Assumes a 10 MHz system clock and a periodic processing cycle derived from it.
package sim_pkg;

  // System clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Cycles of clk in one millisecond.
  localparam int unsigned CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  // Processing cycle period in clk cycles (one processor system cycle).
  localparam int unsigned PROC_CYC_LEN = 10000;
  localparam logic [13:0] PROC_CYC_LAST = 14'(PROC_CYC_LEN - 1);

  // On-delay range and default in milliseconds.
  localparam int unsigned ON_DELAY_MAX_MS = 120000;
  localparam logic [16:0] ON_DELAY_DEF_MS = 17'h00014;
  // On-delay counts are kept in processing cycles, one cycle per millisecond here.
  localparam int unsigned MS_PER_PROC = (PROC_CYC_LEN + CYC_PER_MS - 1) / CYC_PER_MS;

  // Position limit width and limits.
  localparam int unsigned POS_W = 32;
  localparam int unsigned LIM_W = 31;
  localparam logic [30:0] LIM_MAX = 31'h7FFFFFFF;
  localparam logic [30:0] LIM_DEF = 31'h00000000;

  // Axis assignment encoding.
  localparam logic AXIS_FIRST = 1'b0;
  localparam logic AXIS_SECOND = 1'b1;
  localparam logic AXIS_DEF = AXIS_FIRST;

  // Monitor states, Gray coded along idle, delay, monitor.
  typedef enum logic [1:0] {
    SIM_IDLE  = 2'b00,
    SIM_DELAY = 2'b01,
    SIM_MON   = 2'b11
  } sim_state_t;

endpackage

// ---- sim_tick.sv ----
// Processing cycle tick generator for the limited increment monitor.
// Assumes a free running clk; emits one tick per processor system cycle.
module sim_tick
  import sim_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Tick output.
  output logic      tick
);

  logic [13:0] cnt_ff;

  // Divider counts clk cycles and wraps at the end of each processing cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 14'h0000;
    end else if (clk_en) begin
      cnt_ff <= (cnt_ff == PROC_CYC_LAST) ? 14'h0000 : cnt_ff + 14'h0001;
    end
  end

  // Tick is a one cycle pulse, gated so a frozen block never sees one.
  assign tick = clk_en && (cnt_ff == PROC_CYC_LAST);

endmodule

// ---- sim_monitor.sv ----
// Limited increment monitor for one drive axis, normative or monitoring-only variant.
// Assumes positions, configuration and the arm input are synchronous to clk.
//
// Function
// - Arm input low arms, high disarms.
// - Compare only after configured on-delay elapses.
// - Partial-cycle delay expires at next cycle.
// - Capture start position when monitoring begins.
// - Compare position against limits every cycle.
// - Limits unsigned 0..2147483647, default zero.
// - Normative variant requests brake-ramp stop on violation.
// - Violation drives range acknowledge low.
// - Acknowledge high while active and inside; here a violation latches it low until disarm.
// - Acknowledge low whenever function not armed.
// - Monitoring-only variant requests no stop.
// - Instance assigned to first or second axis.
// - Clockwise rotation counts as positive position.
// - Armed only through arm input.
// - Optional hysteresis defined elsewhere, not built.
module sim_monitor
  import sim_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  // Activation.
  input  wire logic                     arm_input_n,
  // Configuration.
  input  wire logic                     monitored_increment_variant,
  input  wire logic                     second_axis_select,
  input  wire logic [16:0]              on_delay_ms,
  input  wire logic [LIM_W-1:0]         pos_max,
  input  wire logic [LIM_W-1:0]         pos_min,
  // Axis positions, signed, clockwise positive.
  input  wire logic signed [POS_W-1:0]  first_axis_pos,
  input  wire logic signed [POS_W-1:0]  second_axis_pos,
  // Results.
  output logic                          range_acknowledge_out,
  output logic                          brake_ramp_stop_request,
  output logic                          first_axis_stop,
  output logic                          second_axis_stop,
  output logic                          monitoring_active
);

  sim_state_t                state_ff;
  sim_state_t                nxt_state;
  logic [16:0]               delay_ff;
  logic [16:0]               nxt_delay;
  logic signed [POS_W-1:0]   start_ff;
  logic                      ack_ff;
  logic                      stop_ff;
  logic                      axis_ff;
  logic                      tick;
  logic                      armed;
  logic signed [POS_W-1:0]   cur_pos;
  logic signed [POS_W+1:0]   diff;
  logic                      viol;
  logic                      viol_hi;
  logic                      viol_lo;
  logic                      mon_entry;
  logic                      stop_set;
  logic [1:0]                axis_stop;

  // The divider free-runs from reset rather than restarting at arming, so the first
  // tick after arming lands anywhere in a partial cycle; counting whole ticks from
  // there rounds a partial cycle up to the next cycle boundary.
  sim_tick u_tick (
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .tick   (tick)
  );

  // The activation input is the only way in; no permanent mode exists.
  assign armed = !arm_input_n;

  // Axis assignment is sampled at each new activation so it cannot change mid-window.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      axis_ff <= AXIS_DEF;
    end else if (clk_en && state_ff == SIM_IDLE) begin
      axis_ff <= second_axis_select ? AXIS_SECOND : AXIS_FIRST;
    end
  end

  // Position of the assigned axis; positive counts follow clockwise rotation.
  assign cur_pos = (axis_ff == AXIS_SECOND) ? second_axis_pos : first_axis_pos;

  // Signed distance from the start position, two bits wider so no wrap can hide a breach.
  assign diff = (POS_W+2)'(cur_pos) - (POS_W+2)'(start_ff);

  // Strictly beyond start plus max is an upper breach; the bound itself is still inside.
  assign viol_hi = diff > $signed({3'b000, pos_max});

  // Strictly below start minus min is a lower breach.
  assign viol_lo = diff < -$signed({3'b000, pos_min});

  // No hysteresis is applied, so a breach counts at the first tick that sees it.
  // A user who must ride through short overshoots has to widen the window instead.
  assign viol = viol_hi || viol_lo;

  // Sequencer: delay counts whole processing cycles, so a partial cycle rounds up.
  always_comb begin
    nxt_state = state_ff;
    nxt_delay = delay_ff;
    unique case (state_ff)
      SIM_IDLE: begin
        if (armed) begin
          nxt_state = SIM_DELAY;
          nxt_delay = on_delay_ms;
        end
      end
      SIM_DELAY: begin
        if (!armed) begin
          nxt_state = SIM_IDLE;
        end else if (tick) begin
          if (delay_ff <= 17'(MS_PER_PROC)) begin
            nxt_state = SIM_MON;
            nxt_delay = 17'h00000;
          end else begin
            nxt_delay = delay_ff - 17'(MS_PER_PROC);
          end
        end
      end
      SIM_MON: begin
        if (!armed) begin
          nxt_state = SIM_IDLE;
        end
      end
      // The fourth state code is never reached from reset; fall back to idle if it is.
      default: begin
        nxt_state = SIM_IDLE;
      end
    endcase
  end

  // State and delay registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= SIM_IDLE;
      delay_ff <= ON_DELAY_DEF_MS;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      delay_ff <= nxt_delay;
    end
  end

  // Monitoring begins at the tick that ends the delay; start capture and the first
  // acknowledge both key off this one strobe so they cannot drift apart.
  assign mon_entry = (state_ff == SIM_DELAY) && (nxt_state == SIM_MON);

  // Start position is latched on entry to monitoring and cleared on disarm.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_ff <= '0;
    end else if (clk_en) begin
      if (!armed) begin
        start_ff <= '0;
      end else if (mon_entry) begin
        start_ff <= cur_pos;
      end
    end
  end

  // Acknowledge updates once per processing cycle while monitoring; a violation latches
  // until disarm, since a safe stop must not silently clear itself.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else if (clk_en) begin
      if (!armed || state_ff != SIM_MON) begin
        ack_ff <= mon_entry;
      end else if (tick && viol) begin
        ack_ff <= 1'b0;
      end
    end
  end

  // A breach raises a stop only in the normative variant.
  assign stop_set = tick && viol && !monitored_increment_variant;

  // Stop request, latched until disarm.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_ff <= 1'b0;
    end else if (clk_en) begin
      if (!armed || state_ff != SIM_MON) begin
        stop_ff <= 1'b0;
      end else if (stop_set) begin
        stop_ff <= 1'b1;
      end
    end
  end

  // One stop flop per axis, so each axis output comes straight from a register; the
  // latched axis choice steers the request and cannot move while monitoring runs.
  for (genvar g = 0; g < 2; g++) begin : g_axis
    logic stop_ax_ff;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stop_ax_ff <= 1'b0;
      end else if (clk_en) begin
        if (!armed || state_ff != SIM_MON) begin
          stop_ax_ff <= 1'b0;
        end else if (stop_set && axis_ff == ((g == 0) ? AXIS_FIRST : AXIS_SECOND)) begin
          stop_ax_ff <= 1'b1;
        end
      end
    end

    assign axis_stop[g] = stop_ax_ff;
  end

  // Outputs; the stop is steered to the assigned axis only.
  assign range_acknowledge_out   = ack_ff;
  assign brake_ramp_stop_request = stop_ff;
  assign first_axis_stop         = axis_stop[0];
  assign second_axis_stop        = axis_stop[1];
  assign monitoring_active       = (state_ff == SIM_MON);

endmodule

// ---- sim_monitor_chk.sv ----
// Checker for the increment monitor ports.
// Assumes clk_en is held high and a bind by name.
module sim_monitor_chk (
  // Clock, reset and inputs.
  input wire logic clk,
  input wire logic rst,
  input wire logic arm_input_n,
  input wire logic monitored_increment_variant,
  // Results.
  input wire logic range_acknowledge_out,
  input wire logic brake_ramp_stop_request,
  input wire logic first_axis_stop,
  input wire logic second_axis_stop,
  input wire logic monitoring_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so one clocking and one disable.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_idle_ack_low: assert property (arm_input_n |=> !range_acknowledge_out)
    else $error("ack high after disarm");
  a_idle_no_stop: assert property (arm_input_n |=> !brake_ramp_stop_request)
    else $error("stop held after disarm");
  a_stop_only_norm: assert property ($rose(brake_ramp_stop_request)
    |-> !$past(monitored_increment_variant)) else $error("stop in monitor-only variant");
  a_stop_in_mon: assert property ($rose(brake_ramp_stop_request) |-> $past(monitoring_active))
    else $error("stop outside monitoring");
  a_stop_ack_low: assert property (brake_ramp_stop_request |-> !range_acknowledge_out)
    else $error("ack high with stop");
  a_ack_when_mon: assert property (range_acknowledge_out |-> monitoring_active)
    else $error("ack high while not monitoring");
  a_ack_rise_start: assert property ($rose(range_acknowledge_out) |-> $rose(monitoring_active))
    else $error("ack rose away from monitoring start");
  a_mon_needs_arm: assert property ($rose(monitoring_active) |-> !$past(arm_input_n))
    else $error("monitoring without arm");
  a_axis_one_hot: assert property (((first_axis_stop || second_axis_stop)
    == brake_ramp_stop_request) && !(first_axis_stop && second_axis_stop))
    else $error("axis stop not gated to one axis");
endmodule

// ---- sim_axis_model.sv ----
// Axis model: position feedback for two drive axes.
// Assumes the bench sets targets at the falling edge.
module sim_axis_model
  import sim_pkg::*;
(
  // Clock, targets and stops.
  input  wire logic                    clk,
  input  wire logic signed [POS_W-1:0] tgt_a,
  input  wire logic signed [POS_W-1:0] tgt_b,
  input  wire logic                    first_axis_stop,
  input  wire logic                    second_axis_stop,
  // Positions, clockwise positive.
  output logic signed [POS_W-1:0]      first_axis_pos = '0,
  output logic signed [POS_W-1:0]      second_axis_pos = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stopped axis holds still, as a braked shaft would.
  always @(negedge clk) begin
    if (!first_axis_stop) first_axis_pos <= tgt_a;
    if (!second_axis_stop) second_axis_pos <= tgt_b;
  end
endmodule

// ---- sim_monitor_tb.sv ----
// Bench for the increment monitor: random windows, three arming cases.
// Assumes one processing tick every PROC_CYC_LEN clocks.
module sim_monitor_tb
  import sim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int L = PROC_CYC_LEN;
  logic                    clk = 0, rst = 1, arm_n = 1, var_m = 0, ax2 = 0;
  logic [16:0]             dly = '0;
  logic [LIM_W-1:0]        pmax = '0, pmin = '0;
  logic signed [POS_W-1:0] ta = '0, tb = '0, pa, pb;
  logic                    ack, stp, st1, st2, act;
  int                      mismatches = 0, num_checks = 0, cyc = 0;
  sim_monitor sim_monitor_i (.clk(clk), .rst(rst), .clk_en(1'b1), .arm_input_n(arm_n),
    .monitored_increment_variant(var_m), .second_axis_select(ax2), .on_delay_ms(dly),
    .pos_max(pmax), .pos_min(pmin), .first_axis_pos(pa), .second_axis_pos(pb),
    .range_acknowledge_out(ack), .brake_ramp_stop_request(stp), .first_axis_stop(st1),
    .second_axis_stop(st2), .monitoring_active(act));
  sim_axis_model sim_axis_model_i (.clk(clk), .tgt_a(ta), .tgt_b(tb), .first_axis_stop(st1),
    .second_axis_stop(st2), .first_axis_pos(pa), .second_axis_pos(pb));
  // Free running 10 MHz clock.
  initial forever #50 clk = ~clk;
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Strictly beyond a bound is a breach, so the bound itself is inside.
  function automatic logic in_window(longint p, longint s, longint mx, longint mn);
    return (p <= s + mx) && (p >= s - mn);
  endfunction
  // Only the assigned axis moves; the other sits far outside to show it is ignored.
  task automatic run_case(logic v, logic a2, int d, logic up);
    longint base, p;
    int n;
    base = longint'($urandom_range(2000)) - 1000;
    pmax = 31'($urandom_range(500, 1));
    pmin = 31'($urandom_range(500, 1));
    {var_m, ax2, dly} = {v, a2, 17'(d)};
    ta <= 32'(a2 ? base + 99999 : base);
    tb <= 32'(a2 ? base : base - 99999);
    @(negedge clk);
    arm_n = 0;
    n = 0;
    while (act !== 1'b1 && n < 3 * L) begin
      @(negedge clk);
      n++;
    end
    chk("delay", 1, n > (d - 1) * L && n <= (d > 1 ? d : 1) * L + 1);
    chk("ack start", 1, ack);
    for (int k = 0; k < 2; k++) begin
      p = up ? base + pmax + k : base - pmin - k;
      // Non-blocking targets reach the model one falling edge later, every time.
      if (a2) tb <= 32'(p);
      else ta <= 32'(p);
      repeat (L + 1) @(negedge clk);
      chk("ack", in_window(p, base, pmax, pmin), ack);
    end
    chk("stop", !v, stp);
    chk("axis stops", {!v && !a2, !v && a2}, {st1, st2});
    arm_n = 1;
    repeat (2) @(negedge clk);
    chk("disarmed", 0, {ack, stp, act});
    $display("case done: variant %0d axis %0d delay %0d", v, a2, d);
  endtask
  // Hang guard sized a little above the ten ticks the three cases take at most.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 104000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h228B));
    repeat (10) @(negedge clk);
    chk("reset outs", 0, {ack, stp, st1, st2, act});
    rst = 0;
    run_case(1'b0, 1'b0, 2, 1'b1);
    run_case(1'b1, 1'b1, 0, 1'b0);
    run_case(1'b0, 1'b1, 1, 1'b0);
    conclude();
  end
endmodule
bind sim_monitor sim_monitor_chk sim_monitor_chk_i (.clk(clk), .rst(rst),
  .arm_input_n(arm_input_n), .monitored_increment_variant(monitored_increment_variant),
  .range_acknowledge_out(range_acknowledge_out), .first_axis_stop(first_axis_stop),
  .brake_ramp_stop_request(brake_ramp_stop_request), .second_axis_stop(second_axis_stop),
  .monitoring_active(monitoring_active));
